// ---- pkg/bist_seq_defs.svh ----
// constants for the microprogram sequencer
// assumes AXI4-Lite register access, one test clock
// Overview of operation
// - bank hold keeps bank segment
// - bank increment steps upward
// - bank decrement steps downward
// - load-lower loads lower bound value
// - load-upper loads upper bound value
// - bank commands only with bank bits
// - active loop may modify bank command
// - counters hold or step by one
// - counters step only on final tick
// - wait increment only without refresh scheduling
// - all conditions met: next sequential word
// - only loop pending: loop jump target
// - any unmet condition: own jump target
// - empty condition set requires nothing
// - row-low terminal at range end
// - row-high terminal at range end
// - row-low terminal required only when enabled
// - row-high terminal required only when enabled
// - row-low terminal needs permit, bits, width
// - row-low trigger needs row-low counting
// - row-high trigger needs counting, row bits
// - loop unit has three modifying entries
// - bank terminal at range end
// - general counter terminal at end value
`ifndef BIST_SEQ_DEFS_SVH
`define BIST_SEQ_DEFS_SVH
`define BANK_BITS    3
`define ROW_BITS     3
`define OFS_CTRL     7'h00
`define OFS_STAT     7'h04
`define OFS_RANGE    7'h08
`define OFS_LOAD     7'h0C
`define OFS_CEND     7'h10
`define OFS_LOOP     7'h14
`define OFS_ADDR     7'h18
`define OFS_CNT      7'h1C
`define OFS_IMEM     7'h40
`define IMEM_DEPTH   8
`define RST_WORD     32'h0000_0000
`define RESP_OK      2'h0
`define RESP_ERR     2'h2
`define SEG_MIN      3'h0
`define SEG_ONE      3'h1
`define CNT_ONE      8'h01
`endif

// ---- pkg/bist_seq_pkg.sv ----
// types shared by the sequencer and its bench
// assumes bist_seq_defs.svh for numeric constants
package bist_seq_pkg;
   typedef enum logic [2:0] {
      SEG_HOLD = 3'h0, SEG_INC = 3'h1, SEG_DEC = 3'h2,
      SEG_LDMIN = 3'h3, SEG_LDMAX = 3'h4
   } seg_cmd_e;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001, ST_RUN = 3'b010, ST_DONE = 3'b100
   } state_e;
   // one instruction word
   typedef struct packed {
      logic [7:0] spare;
      logic       last;
      logic [2:0] op_len;
      logic [2:0] jump_target;
      logic       loop_req;
      logic       need_wait;
      logic       need_cnta;
      logic       need_bank;
      logic       need_rhigh;
      logic       need_rlow;
      logic       wait_inc;
      logic       cnta_inc;
      seg_cmd_e   rhigh_cmd;
      seg_cmd_e   rlow_cmd;
      seg_cmd_e   bank_cmd;
   } instr_s;
   typedef struct packed {
      logic [1:0] spare;
      logic       inh_cmp;
      logic       inh_last;
      logic       wr_inv;
      logic       exp_inv;
      logic       addr_inv;
      logic       enable;
   } loop_entry_s;
   typedef struct packed {
      logic [2:0] bank;
      logic [2:0] row_high;
      logic [2:0] row_low;
      logic       exp_inv;
      logic       wr_inv;
      logic       cmp_en;
   } seq_out_s;
endpackage : bist_seq_pkg

// ---- rtl/bist_microprogram_sequencer.sv ----
// memory self-test instruction sequencer
// assumes AXI4-Lite master on CLOCK, memory driven from SEQ_OUT
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "bist_seq_defs.svh"
module bist_microprogram_sequencer (
   // clock and reset
   input  wire logic                   CLOCK,
   input  wire logic                   RST,
   // axi4-lite write
   input  wire logic [6:0]             S_AXI_AWADDR,
   input  wire logic                   S_AXI_AWVALID,
   output logic                        S_AXI_AWREADY,
   input  wire logic [31:0]            S_AXI_WDATA,
   input  wire logic [3:0]             S_AXI_WSTRB,
   input  wire logic                   S_AXI_WVALID,
   output logic                        S_AXI_WREADY,
   output logic [1:0]                  S_AXI_BRESP,
   output logic                        S_AXI_BVALID,
   input  wire logic                   S_AXI_BREADY,
   // axi4-lite read
   input  wire logic [6:0]             S_AXI_ARADDR,
   input  wire logic                   S_AXI_ARVALID,
   output logic                        S_AXI_ARREADY,
   output logic [31:0]                 S_AXI_RDATA,
   output logic [1:0]                  S_AXI_RRESP,
   output logic                        S_AXI_RVALID,
   input  wire logic                   S_AXI_RREADY,
   // memory side
   output bist_seq_pkg::seq_out_s      SEQ_OUT,
   output logic                        LAST_TICK,
   output logic [2:0]                  PC,
   output logic                        DONE
);
   import bist_seq_pkg::*;

   localparam logic HAS_BANK = (`BANK_BITS > 0);
   localparam logic HAS_ROW  = (`ROW_BITS > 0);

   ////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [2:0] seg_next(
      seg_cmd_e c, logic [2:0] v, logic [2:0] mx,
      logic [2:0] lmin, logic [2:0] lmax);
      unique case (c)
         SEG_INC:   seg_next = (v == mx) ? `SEG_MIN : v + `SEG_ONE;
         SEG_DEC:   seg_next = (v == `SEG_MIN) ? mx : v - `SEG_ONE;
         SEG_LDMIN: seg_next = lmin;
         SEG_LDMAX: seg_next = lmax;
         default:   seg_next = v;
      endcase
   endfunction : seg_next

   function automatic logic seg_term(
      seg_cmd_e c, logic [2:0] v, logic [2:0] mx);
      seg_term = (c == SEG_INC && v == mx) ||
                 (c == SEG_DEC && v == `SEG_MIN);
   endfunction : seg_term

   function automatic seg_cmd_e seg_mod(seg_cmd_e c, logic inv);
      seg_mod = c;
      if (inv && c == SEG_INC) begin
         seg_mod = SEG_DEC;
      end else if (inv && c == SEG_DEC) begin
         seg_mod = SEG_INC;
      end
   endfunction : seg_mod

   function automatic logic [31:0] merge(
      logic [31:0] o, logic [31:0] n, logic [3:0] s);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
      end
   endfunction : merge

   ////////////////////////////////////////////////////////////
   // registers
   logic [31:0]  ctrl_q, range_q, load_q, cend_q, loop_q;
   logic [31:0]  imem_q [`IMEM_DEPTH];
   logic         bvalid_q, rvalid_q;
   logic [1:0]   bresp_q, rresp_q;
   logic [31:0]  rdata_q;
   logic         wr_go;
   logic         wr_hit;

   wire logic run_en     = ctrl_q[0];
   wire logic refresh_on = ctrl_q[1];
   wire logic low_perm   = ctrl_q[2];
   wire logic [1:0] rl_width = ctrl_q[5:4];
   wire logic [2:0] bank_max = range_q[2:0];
   wire logic [2:0] row_max  = range_q[10:8];
   wire logic [2:0] ld_min   = load_q[2:0];
   wire logic [2:0] ld_max   = load_q[10:8];
   wire logic [7:0] cnta_end = cend_q[7:0];
   wire logic [7:0] wait_end = cend_q[15:8];
   wire logic [2:0] loop_tgt = loop_q[2:0];

   assign wr_go = S_AXI_AWVALID && S_AXI_WVALID && !bvalid_q;
   assign S_AXI_AWREADY = wr_go;
   assign S_AXI_WREADY  = wr_go;
   assign S_AXI_ARREADY = !rvalid_q;
   assign S_AXI_BVALID  = bvalid_q;
   assign S_AXI_BRESP   = bresp_q;
   assign S_AXI_RVALID  = rvalid_q;
   assign S_AXI_RRESP   = rresp_q;
   assign S_AXI_RDATA   = rdata_q;

   wire logic [6:0] wa = S_AXI_AWADDR & 7'h7C;
   assign wr_hit = wa <= `OFS_LOOP ||
                   (wa >= `OFS_IMEM && wa[6:5] == 2'h2);

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         ctrl_q  <= `RST_WORD;
         range_q <= `RST_WORD;
         load_q  <= `RST_WORD;
         cend_q  <= `RST_WORD;
         loop_q  <= `RST_WORD;
         for (int i = 0; i < `IMEM_DEPTH; i++) begin
            imem_q[i] <= `RST_WORD;
         end
      end else if (wr_go) begin
         unique case (wa)
            `OFS_CTRL:  ctrl_q  <= merge(ctrl_q, S_AXI_WDATA, S_AXI_WSTRB);
            `OFS_RANGE: range_q <= merge(range_q, S_AXI_WDATA, S_AXI_WSTRB);
            `OFS_LOAD:  load_q  <= merge(load_q, S_AXI_WDATA, S_AXI_WSTRB);
            `OFS_CEND:  cend_q  <= merge(cend_q, S_AXI_WDATA, S_AXI_WSTRB);
            `OFS_LOOP:  loop_q  <= merge(loop_q, S_AXI_WDATA, S_AXI_WSTRB);
            default: begin
               if (wa >= `OFS_IMEM && wa[6:5] == 2'h2) begin
                  imem_q[wa[4:2]] <= merge(imem_q[wa[4:2]], S_AXI_WDATA,
                                           S_AXI_WSTRB);
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `RESP_OK;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_hit ? `RESP_OK : `RESP_ERR;
      end else if (S_AXI_BREADY) begin
         bvalid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////
   // sequencer state
   state_e      state_q;
   logic [2:0]  pc_q, tick_q;
   logic [1:0]  pass_q;
   logic [2:0]  bank_q, rlow_q, rhigh_q;
   logic [7:0]  cnta_q, wait_q;
   instr_s      ins;
   loop_entry_s ent;
   seg_cmd_e    bank_c, rlow_c, rhigh_c;
   logic        fin, t_rlow, t_rhigh, t_bank, t_cnta, t_wait;
   logic        all_ok, loop_done, go_seq, hold_addr;
   logic        cnta_step, wait_step, rlow_ok;
   logic [2:0]  rl_max;
   logic [1:0]  next_pass;

   assign ins = instr_s'(imem_q[pc_q]);
   assign ent = loop_entry_s'(loop_q[8*pass_q +: 8]);
   assign fin = state_q == ST_RUN && tick_q == ins.op_len;
   assign rl_max = row_max & ((3'h1 << rl_width) - `SEG_ONE);
   assign rlow_ok = low_perm && HAS_ROW && rl_width != 2'h0;

   // loop entries modify commands on repeat passes
   wire logic mod_on = pass_q != 2'h0 && ent.enable;
   assign bank_c  = HAS_BANK ? seg_mod(ins.bank_cmd,
                    mod_on && ent.addr_inv) : SEG_HOLD;
   assign rlow_c  = rlow_ok ? seg_mod(ins.rlow_cmd,
                    mod_on && ent.addr_inv) : SEG_HOLD;
   assign rhigh_c = HAS_ROW ? seg_mod(ins.rhigh_cmd,
                    mod_on && ent.addr_inv) : SEG_HOLD;

   assign t_rlow  = rlow_ok && seg_term(rlow_c, rlow_q, rl_max);
   assign t_rhigh = HAS_ROW && seg_term(rhigh_c, rhigh_q, row_max);
   assign t_bank  = HAS_BANK && seg_term(bank_c, bank_q, bank_max);
   assign cnta_step = ins.cnta_inc;
   assign wait_step = ins.wait_inc && !refresh_on;
   assign t_cnta  = cnta_step && cnta_q + `CNT_ONE == cnta_end;
   assign t_wait  = wait_step && wait_q + `CNT_ONE == wait_end;

   // unrequested triggers default to satisfied
   assign all_ok = (!ins.need_rlow  || t_rlow)  &&
                   (!ins.need_rhigh || t_rhigh) &&
                   (!ins.need_bank  || t_bank)  &&
                   (!ins.need_cnta  || t_cnta)  &&
                   (!ins.need_wait  || t_wait);

   // next enabled entry after the current pass
   always_comb begin
      next_pass = 2'h0;
      for (int i = 3; i >= 1; i--) begin
         if (i > pass_q && loop_q[8*i]) begin
            next_pass = 2'(i);
         end
      end
   end
   assign loop_done = !ins.loop_req || next_pass == 2'h0;
   assign go_seq = all_ok && loop_done;
   assign hold_addr = mod_on && ent.inh_last && go_seq;

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: if (run_en) state_q <= ST_RUN;
            ST_RUN: begin
               if (!run_en) begin
                  state_q <= ST_IDLE;
               end else if (fin && go_seq && ins.last) begin
                  state_q <= ST_DONE;
               end
            end
            ST_DONE: if (!run_en) state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         tick_q <= `SEG_MIN;
      end else if (state_q != ST_RUN || fin) begin
         tick_q <= `SEG_MIN;
      end else begin
         tick_q <= tick_q + `SEG_ONE;
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         pc_q   <= `SEG_MIN;
         pass_q <= 2'h0;
      end else if (state_q == ST_IDLE) begin
         pc_q   <= `SEG_MIN;
         pass_q <= 2'h0;
      end else if (fin) begin
         if (!all_ok) begin
            pc_q <= ins.jump_target;
         end else if (!loop_done) begin
            pc_q   <= loop_tgt;
            pass_q <= next_pass;
         end else begin
            pc_q   <= ins.last ? pc_q : pc_q + `SEG_ONE;
            pass_q <= 2'h0;
         end
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         bank_q  <= `SEG_MIN;
         rlow_q  <= `SEG_MIN;
         rhigh_q <= `SEG_MIN;
      end else if (fin && !hold_addr) begin
         bank_q  <= seg_next(bank_c, bank_q, bank_max,
                             ld_min, ld_max);
         rlow_q  <= seg_next(rlow_c, rlow_q, rl_max, ld_min, ld_max);
         rhigh_q <= seg_next(rhigh_c, rhigh_q, row_max, ld_min, ld_max);
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         cnta_q <= 8'h00;
         wait_q <= 8'h00;
      end else if (state_q == ST_IDLE) begin
         cnta_q <= 8'h00;
         wait_q <= 8'h00;
      end else if (fin) begin
         if (cnta_step) cnta_q <= cnta_q + `CNT_ONE;
         if (wait_step) wait_q <= wait_q + `CNT_ONE;
      end
   end

   ////////////////////////////////////////////////////////////
   // read path
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         rvalid_q <= 1'b0;
         rresp_q  <= `RESP_OK;
         rdata_q  <= `RST_WORD;
      end else if (S_AXI_ARVALID && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rresp_q  <= `RESP_OK;
         unique case (S_AXI_ARADDR & 7'h7C)
            `OFS_CTRL:  rdata_q <= ctrl_q;
            `OFS_STAT:  rdata_q <= {24'h0, pass_q, state_q, pc_q};
            `OFS_RANGE: rdata_q <= range_q;
            `OFS_LOAD:  rdata_q <= load_q;
            `OFS_CEND:  rdata_q <= cend_q;
            `OFS_LOOP:  rdata_q <= loop_q;
            `OFS_ADDR:  rdata_q <= {23'h0, bank_q, rhigh_q, rlow_q};
            `OFS_CNT:   rdata_q <= {16'h0, wait_q, cnta_q};
            default: begin
               if (S_AXI_ARADDR[6:5] == 2'h2) begin
                  rdata_q <= imem_q[S_AXI_ARADDR[4:2]];
               end else begin
                  rdata_q <= `RST_WORD;
                  rresp_q <= `RESP_ERR;
               end
            end
         endcase
      end else if (S_AXI_RREADY) begin
         rvalid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////
   // outputs
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         SEQ_OUT <= '0;
      end else begin
         SEQ_OUT.bank     <= bank_q;
         SEQ_OUT.row_high <= rhigh_q;
         SEQ_OUT.row_low  <= rlow_q;
         SEQ_OUT.exp_inv  <= mod_on && ent.exp_inv;
         SEQ_OUT.wr_inv   <= mod_on && ent.wr_inv;
         SEQ_OUT.cmp_en   <= state_q == ST_RUN &&
                             !(mod_on && ent.inh_cmp);
      end
   end
   assign LAST_TICK = fin;
   assign PC   = pc_q;
   assign DONE = state_q == ST_DONE;

   ////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);

   chk_bank_hold: assert property (fin && bank_c == SEG_HOLD
      |=> bank_q == $past(bank_q)) else $error("bank moved on hold");
   chk_bank_inc: assert property (fin && !hold_addr && bank_c == SEG_INC
      && bank_q != bank_max |=> bank_q == $past(bank_q) + `SEG_ONE)
      else $error("bank increment wrong");
   chk_bank_dec: assert property (fin && !hold_addr && bank_c == SEG_DEC
      && bank_q != `SEG_MIN |=> bank_q == $past(bank_q) - `SEG_ONE)
      else $error("bank decrement wrong");
   chk_load_min: assert property (fin && !hold_addr
      && bank_c == SEG_LDMIN |=> bank_q == $past(ld_min))
      else $error("bank lower load wrong");
   chk_load_max: assert property (fin && !hold_addr
      && bank_c == SEG_LDMAX |=> bank_q == $past(ld_max))
      else $error("bank upper load wrong");
   chk_cnt_final: assert property (state_q != ST_IDLE && !fin |=> cnta_q == $past(cnta_q))
      else $error("counter moved mid instruction");
   chk_wait_gate: assert property (refresh_on && state_q != ST_IDLE
      |=> wait_q == $past(wait_q)) else $error("wait counted");
   chk_jump_own: assert property (fin && !all_ok
      |=> pc_q == $past(ins.jump_target)) else $error("bad jump");
   chk_jump_loop: assert property (fin && all_ok && !loop_done
      |=> pc_q == $past(loop_tgt)) else $error("bad loop jump");
endmodule : bist_microprogram_sequencer

// ---- tb/mem_under_test_model.sv ----
// behavioural memory under test, fed by the sequencer's address outputs
// assumes seq_out_s from bist_seq_pkg and a single test clock
`timescale 1ns/10ps
module mem_under_test_model
   import bist_seq_pkg::*;
(
   // clock
   input  wire logic                     clock,
   // address and data control from the sequencer
   input  wire bist_seq_pkg::seq_out_s   seq_in,
   // activity seen
   output logic [7:0]                    access_cnt
);
   logic [7:0] cells_q [512];

   initial begin
      access_cnt = 8'h00;
   end

   // one access per compare-enabled cycle, data polarity from the loop entry
   always @(posedge clock) begin
      if (seq_in.cmp_en === 1'b1) begin
         cells_q[{seq_in.bank, seq_in.row_high, seq_in.row_low}] <= seq_in.wr_inv ? 8'hFF : 8'h00;
         access_cnt <= access_cnt + 8'h01;
      end
   end
endmodule : mem_under_test_model

// ---- tb/tb_bist_microprogram_sequencer.sv ----
// self-checking bench for the microprogram sequencer
// assumes the design's axi4-lite map and instruction word layout
`timescale 1ns/10ps
`include "bist_seq_defs.svh"
module tb_bist_microprogram_sequencer;
   import bist_seq_pkg::*;
   typedef struct {string name; logic [33:0] exp;} note_t;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic [6:0]  awaddr = 7'h00;
   logic        awvalid = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic [6:0]  araddr = 7'h00;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, last_tick, done;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [2:0]  pc;
   logic [7:0]  access_cnt;
   seq_out_s    seq_out;
   int          failures = 0;
   int          checked = 0;
   int          ticks = 0;
   int          i;
   note_t       notes[$];
   instr_s      prog [5];

   initial begin
      forever #12.5 clock = ~clock;
   end

   bist_microprogram_sequencer u_bist_microprogram_sequencer (
      .CLOCK(clock), .RST(rst),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .SEQ_OUT(seq_out), .LAST_TICK(last_tick), .PC(pc), .DONE(done));

   mem_under_test_model u_mem_under_test_model (.clock(clock), .seq_in(seq_out), .access_cnt(access_cnt));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [33:0] seen, input logic [33:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test

   // address and data offered together, each dropped when taken
   task automatic wr(input logic [6:0] a, input logic [31:0] d, input logic [1:0] resp);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      notes.push_back('{$sformatf("write %h", a), {resp, 32'h0000_0000}});
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clock);
         if (awvalid && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge clock);
   endtask : wr

   task automatic rd(input logic [6:0] a, input logic [31:0] d, input logic [1:0] resp, input string name);
      notes.push_back('{name, {resp, d}});
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clock); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clock); while (rvalid !== 1'b1);
   endtask : rd

   // wait for the done level, then let the registered outputs settle
   task automatic wait_done;
      int n;
      n = 0;
      while (done !== 1'b1 && n < 3000) begin
         @(posedge clock);
         n++;
      end
      repeat (2) @(posedge clock);
   endtask : wait_done

   ////////////////////////////////////////////////////////////////////////
   // response watcher: oldest note against each completed response
   always @(posedge clock) begin : watch
      note_t n;
      if (!rst && ((bvalid && bready) || (rvalid && rready))) begin
         if (notes.size() == 0) begin
            failures++;
            $display("[FAIL] response with no expectation");
         end else begin
            n = notes.pop_front();
            chk(n.name, bvalid ? {bresp, 32'h0000_0000} : {rresp, rdata}, n.exp);
         end
      end
      if (last_tick === 1'b1) ticks++;
   end

   initial begin
      #(25 * 20000);
      failures++;
      stop_test();
   end

   initial begin
      void'($urandom(32'h3ef092cf));
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      bready <= 1'b1;
      rready <= 1'b1;
      @(posedge clock);
      rd(`OFS_STAT, 32'h0000_0008, `RESP_OK, "stat idle");
      rd(7'h20, `RST_WORD, `RESP_ERR, "unmapped read");
      wr(7'h20, $urandom, `RESP_ERR);
      wr(`OFS_RANGE, 32'h0000_0707, `RESP_OK);
      wr(`OFS_LOAD, 32'h0000_0502, `RESP_OK);
      wr(`OFS_CEND, 32'h0000_0003, `RESP_OK);
      rd(`OFS_RANGE, 32'h0000_0707, `RESP_OK, "range");
      // load lower, count up to end of counter, step down, load upper, hold
      for (i = 0; i < 5; i++) begin
         prog[i] = '0;
         prog[i].op_len = 3'($urandom_range(7));
      end
      prog[0].bank_cmd = SEG_LDMIN;
      prog[1].bank_cmd = SEG_INC;
      prog[1].cnta_inc = 1'b1;
      prog[1].need_cnta = 1'b1;
      prog[1].jump_target = 3'h1;
      prog[2].bank_cmd = SEG_DEC;
      prog[2].rlow_cmd = SEG_DEC;
      prog[2].wait_inc = 1'b1;
      prog[3].bank_cmd = SEG_LDMAX;
      prog[4].rhigh_cmd = SEG_INC;
      prog[4].last = 1'b1;
      for (i = 0; i < 5; i++) begin
         wr(`OFS_IMEM + 7'(4 * i), prog[i], `RESP_OK);
      end
      rd(`OFS_IMEM + 7'h08, prog[2], `RESP_OK, "instr word 2");
      wr(`OFS_CTRL, 32'h0000_0035, `RESP_OK);
      wait_done();
      chk("done", {33'h0, done}, 34'h1);
      chk("pc", {31'h0, pc}, 34'h4);
      chk("seq bank", {31'h0, seq_out.bank}, 34'h5);
      chk("last ticks", 34'(ticks), 34'd7);
      chk("memory accesses", {33'h0, access_cnt != 8'h00}, 34'h1);
      rd(`OFS_ADDR, 32'h0000_014F, `RESP_OK, "address");
      rd(`OFS_CNT, 32'h0000_0103, `RESP_OK, "counters");
      rd(`OFS_STAT, 32'h0000_0024, `RESP_OK, "stat done");
      wr(`OFS_CTRL, 32'h0000_0034, `RESP_OK);
      // pc clears one edge after the state falls back to idle
      @(posedge clock);
      rd(`OFS_STAT, 32'h0000_0008, `RESP_OK, "stat stopped");
      rd(`OFS_CNT, `RST_WORD, `RESP_OK, "counters cleared");
      // load upper, count row-low up, repeat once inverted with last count inhibited
      wr(`OFS_LOOP, 32'h0000_1301, `RESP_OK);
      for (i = 0; i < 2; i++) begin
         prog[i] = '0;
         prog[i].op_len = 3'($urandom_range(7));
      end
      prog[0].rlow_cmd = SEG_LDMAX;
      prog[1].rlow_cmd = SEG_INC;
      prog[1].need_rlow = 1'b1;
      prog[1].jump_target = 3'h1;
      prog[1].loop_req = 1'b1;
      prog[1].wait_inc = 1'b1;
      prog[1].last = 1'b1;
      for (i = 0; i < 2; i++) begin
         wr(`OFS_IMEM + 7'(4 * i), prog[i], `RESP_OK);
      end
      wr(`OFS_CTRL, 32'h0000_0037, `RESP_OK);
      wait_done();
      chk("loop done", {33'h0, done}, 34'h1);
      chk("loop pc", {31'h0, pc}, 34'h1);
      chk("loop ticks", 34'(ticks), 34'd12);
      chk("seq row low", {31'h0, seq_out.row_low}, 34'h0);
      rd(`OFS_ADDR, 32'h0000_0148, `RESP_OK, "loop address");
      rd(`OFS_CNT, `RST_WORD, `RESP_OK, "wait gated");
      rd(`OFS_STAT, 32'h0000_0021, `RESP_OK, "loop stat done");
      repeat (2) @(posedge clock);
      stop_test();
   end
endmodule : tb_bist_microprogram_sequencer
